/* File: logic/tie_pkg.sv */
// Purpose: shared constants for the timer interrupt-enable block
// Assumes: 32-bit register port, byte addresses
// Notes: bit layout is four bits per timer, bit 3 of each nibble unused

package tie_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] TIE_ADDR_STATUS = 8'h60; // status, write one clears
  localparam logic [7:0] TIE_ADDR_MASK = 8'h64;   // interrupt output mask
  localparam logic [7:0] TIE_ADDR_EN_SET = 8'h6c; // irq_enable_set
  localparam logic [7:0] TIE_ADDR_EN_CLR = 8'h70; // irq_enable_clear
  localparam logic [7:0] TIE_ADDR_EN_RD = 8'h78;  // enable readback

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int TIE_TIMERS = 6;                   // number of timers
  localparam int TIE_NIB = 4;                      // bits per timer
  localparam int TIE_POS_A = 0;                    // first match source
  localparam int TIE_POS_B = 1;                    // second match source
  localparam int TIE_POS_OVF = 2;                  // overflow source
  localparam logic [31:0] TIE_VALID = 32'h0077_7777; // defined source bits
  localparam logic [31:0] TIE_RST = 32'h0000_0000;   // reset of all regs
  localparam int TIE_CNT_W = 16;                   // counter width

endpackage : tie_pkg

/* File: logic/tie_evt.sv */
// Purpose: one timer's compare and overflow event detector
// Assumes: counter and compares come from the same clock domain
// Notes: match pulses fire on the cycle a value is first reached, the overflow event follows ovf_in every cycle

`timescale 1ns/1ns
`default_nettype none

module tie_evt #(
  parameter int W = tie_pkg::TIE_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] cnt,
  input wire logic [W-1:0] cmp_a,
  input wire logic [W-1:0] cmp_b,
  input wire logic ovf_in,
  output logic [2:0] evt
);
  import tie_pkg::*;

  logic [W-1:0] cnt_prev_reg; // counter last cycle, for first-hit edge
  logic hit_a;                // counter equals first compare
  logic hit_b;                // counter equals second compare

  // ----------------------------------------------------------------------
  // match detection
  // ----------------------------------------------------------------------
  assign hit_a = (cnt == cmp_a) && (cnt_prev_reg != cmp_a); // RULE9
  assign hit_b = (cnt == cmp_b) && (cnt_prev_reg != cmp_b); // RULE9

  // remembers last counter value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_prev_reg <= '0;
    end else begin
      cnt_prev_reg <= cnt;
    end
  end

  // event vector in source bit order
  always_comb begin
    evt = 3'h0;
    evt[TIE_POS_A] = hit_a;
    evt[TIE_POS_B] = hit_b;
    evt[TIE_POS_OVF] = ovf_in; // RULE9
  end

endmodule : tie_evt

`default_nettype wire

/* File: logic/tie_top.sv */
// Purpose: interrupt enable set/clear gating for six timers
// Assumes: single 20 MHz clock, timer inputs on the same clock
// Notes: sources disabled drop out of status and interrupt output
//
// Functional notes
// RULE1: set register ones turn enables on
// RULE2: clear register ones turn enables off
// RULE3: timer one sources at bits 0..2
// RULE4: timer two sources at bits 4..6
// RULE5: timer three sources at bits 8..10
// RULE6: timer four sources at bits 12..14
// RULE7: timer five sources at bits 16..18
// RULE8: timer six sources at bits 20..22
// RULE9: match on compare equal, overflow on wrap
// RULE10: events raise interrupt and set status
// RULE11: enables reset off, gate, reserved ignored
// RULE12: clear bit 18 disables timer five overflow
//
// The address-and-strobe port was decided locally.

`timescale 1ns/1ns
`default_nettype none

module tie_top #(
  parameter int W = tie_pkg::TIE_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [6*W-1:0] tmr_cnt,
  input wire logic [6*W-1:0] tmr_cmp_a,
  input wire logic [6*W-1:0] tmr_cmp_b,
  input wire logic [5:0] tmr_ovf,
  output logic irq
);
  import tie_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [31:0] irq_en_reg;     // one enable per source
  logic [31:0] irq_status_reg; // sticky event flags
  logic [31:0] irq_mask_reg;   // one means passed to irq
  logic [31:0] evt_vec;        // raw events at source bit positions
  logic [31:0] rdata_next;     // read mux output
  logic wr_set;                // write to irq_enable_set
  logic wr_clr;                // write to irq_enable_clear
  logic wr_sts;                // write to status
  logic wr_msk;                // write to mask
  logic [3*TIE_TIMERS-1:0] ev_all; // three events per timer, flat

  // maps timer and source to its register bit, four bits per timer
  // RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
  function automatic int src_bit(input int t, input int s);
    return t * TIE_NIB + s;
  endfunction : src_bit

  // ----------------------------------------------------------------------
  // event detectors
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < TIE_TIMERS; g++) begin : g_tmr
      // flat vector so the placement loop can index it by variable
      tie_evt #(.W(W)) u_evt (
        .clk(clk),
        .sys_rst(sys_rst),
        .cnt(tmr_cnt[g*W +: W]),
        .cmp_a(tmr_cmp_a[g*W +: W]),
        .cmp_b(tmr_cmp_b[g*W +: W]),
        .ovf_in(tmr_ovf[g]),
        .evt(ev_all[g*3 +: 3])
      );
    end
  endgenerate

  // places each timer's events into its nibble
  always_comb begin
    evt_vec = 32'h0;
    for (int t = 0; t < TIE_TIMERS; t++) begin
      evt_vec[src_bit(t, TIE_POS_A)] = ev_all[t*3 + 0];   // RULE9
      evt_vec[src_bit(t, TIE_POS_B)] = ev_all[t*3 + 1];   // RULE9
      evt_vec[src_bit(t, TIE_POS_OVF)] = ev_all[t*3 + 2]; // RULE9
    end
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  assign wr_set = reg_wr && (reg_addr == TIE_ADDR_EN_SET);
  assign wr_clr = reg_wr && (reg_addr == TIE_ADDR_EN_CLR);
  assign wr_sts = reg_wr && (reg_addr == TIE_ADDR_STATUS);
  assign wr_msk = reg_wr && (reg_addr == TIE_ADDR_MASK);

  // ----------------------------------------------------------------------
  // enable flip-flops
  // ----------------------------------------------------------------------
  // set ones, clear ones, zeros and reserved bits have no effect
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_reg <= TIE_RST; // RULE11
    end else if (wr_set) begin
      irq_en_reg <= irq_en_reg | (reg_wdata & TIE_VALID); // RULE1
    end else if (wr_clr) begin
      // bit 18 is timer five overflow, same as in set
      irq_en_reg <= irq_en_reg & ~(reg_wdata & TIE_VALID); // RULE2 RULE12
    end
  end

  // ----------------------------------------------------------------------
  // status and mask
  // ----------------------------------------------------------------------
  // enabled events set status, set wins over write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_reg <= TIE_RST;
    end else begin
      irq_status_reg <= ((wr_sts ? irq_status_reg & ~reg_wdata
                                 : irq_status_reg)
                         | (evt_vec & irq_en_reg)) & TIE_VALID; // RULE10
    end
  end

  // mask register, one passes the status bit to irq
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= TIE_RST;
    end else if (wr_msk) begin
      irq_mask_reg <= reg_wdata & TIE_VALID;
    end
  end

  // interrupt output, registered; only enabled sources reach it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg & irq_en_reg); // RULE11
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_comb begin
    if (reg_addr == TIE_ADDR_STATUS) begin
      rdata_next = irq_status_reg;
    end else if (reg_addr == TIE_ADDR_MASK) begin
      rdata_next = irq_mask_reg;
    end else if (reg_addr == TIE_ADDR_EN_RD) begin
      rdata_next = irq_en_reg;
    end else begin
      rdata_next = 32'h0; // set, clear and unmapped read zero
    end
  end

  // read data valid only the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // a set write turns each written defined bit on
  a_set_turns_on: assert property (@(posedge clk) // RULE1
    disable iff (sys_rst)
    wr_set |=> ((irq_en_reg & $past(reg_wdata) & TIE_VALID)
                == ($past(reg_wdata) & TIE_VALID)))
    else $error("set write did not enable");

  // zeros in a set write leave enables alone
  a_set_keeps: assert property (@(posedge clk) // RULE1
    disable iff (sys_rst)
    wr_set |=> ((irq_en_reg & ~$past(reg_wdata))
                == ($past(irq_en_reg) & ~$past(reg_wdata))))
    else $error("set write changed zero bits");

  // a clear write turns each written bit off
  a_clr_turns_off: assert property (@(posedge clk) // RULE2
    disable iff (sys_rst)
    wr_clr |=> ((irq_en_reg & $past(reg_wdata)) == 32'h0))
    else $error("clear write did not disable");

  // zeros in a clear write leave enables alone
  a_clr_keeps: assert property (@(posedge clk) // RULE2
    disable iff (sys_rst)
    wr_clr |=> ((irq_en_reg & ~$past(reg_wdata))
                == ($past(irq_en_reg) & ~$past(reg_wdata))))
    else $error("clear write changed zero bits");

  // reserved enable bits never hold a one
  a_reserved_zero: assert property (@(posedge clk) // RULE11
    disable iff (sys_rst)
    (irq_en_reg & ~TIE_VALID) == 32'h0)
    else $error("reserved enable bit set");

  // timer one overflow lands at bit 2
  a_t1_ovf_bit: assert property (@(posedge clk) // RULE3
    disable iff (sys_rst)
    (tmr_ovf[0] && irq_en_reg[2]) |=> irq_status_reg[2])
    else $error("timer one overflow not at bit 2");

  // timer two overflow lands at bit 6
  a_t2_ovf_bit: assert property (@(posedge clk) // RULE4
    disable iff (sys_rst)
    (tmr_ovf[1] && irq_en_reg[6]) |=> irq_status_reg[6])
    else $error("timer two overflow not at bit 6");

  // timer three overflow lands at bit 10
  a_t3_ovf_bit: assert property (@(posedge clk) // RULE5
    disable iff (sys_rst)
    (tmr_ovf[2] && irq_en_reg[10]) |=> irq_status_reg[10])
    else $error("timer three overflow not at bit 10");

  // timer four overflow lands at bit 14
  a_t4_ovf_bit: assert property (@(posedge clk) // RULE6
    disable iff (sys_rst)
    (tmr_ovf[3] && irq_en_reg[14]) |=> irq_status_reg[14])
    else $error("timer four overflow not at bit 14");

  // timer five overflow lands at bit 18
  a_t5_ovf_bit: assert property (@(posedge clk) // RULE7
    disable iff (sys_rst)
    (tmr_ovf[4] && irq_en_reg[18]) |=> irq_status_reg[18])
    else $error("timer five overflow not at bit 18");

  // timer six overflow lands at bit 22
  a_t6_ovf_bit: assert property (@(posedge clk) // RULE8
    disable iff (sys_rst)
    (tmr_ovf[5] && irq_en_reg[22]) |=> irq_status_reg[22])
    else $error("timer six overflow not at bit 22");

  // clear bit 18 drops timer five overflow enable
  a_t5_clr_18: assert property (@(posedge clk) // RULE12
    disable iff (sys_rst)
    (wr_clr && reg_wdata[18]) |=> !irq_en_reg[18])
    else $error("clear bit 18 kept timer five overflow");

  // a disabled timer five overflow never reaches status
  a_disabled_quiet: assert property (@(posedge clk) // RULE11
    disable iff (sys_rst)
    (tmr_ovf[4] && !irq_en_reg[18] && !irq_status_reg[18] && !wr_set)
    |=> !irq_status_reg[18])
    else $error("disabled source set status");

  // new status bits only appear where enabled
  a_status_needs_en: assert property (@(posedge clk) // RULE11
    disable iff (sys_rst)
    ((irq_status_reg & ~$past(irq_status_reg) & ~$past(irq_en_reg))
     == 32'h0))
    else $error("status set without enable");

  // reserved status bits never hold a one
  a_status_reserved: assert property (@(posedge clk) // RULE11
    disable iff (sys_rst)
    (irq_status_reg & ~TIE_VALID) == 32'h0)
    else $error("reserved status bit set");

  // first hit of the first compare gives a match event
  a_match_edge: assert property (@(posedge clk) // RULE9
    disable iff (sys_rst)
    (!$past(sys_rst) && (tmr_cnt[W-1:0] == tmr_cmp_a[W-1:0])
     && ($past(tmr_cnt[W-1:0]) != tmr_cmp_a[W-1:0])) |-> evt_vec[0])
    else $error("timer one first match missed");

  // a counter resting on the compare fires only once
  a_match_stays: assert property (@(posedge clk) // RULE9
    disable iff (sys_rst)
    (!$past(sys_rst) && ($past(tmr_cnt[W-1:0]) == tmr_cmp_a[W-1:0]))
    |-> !evt_vec[0])
    else $error("timer one match repeated");

  // any pending unmasked enabled source raises irq
  a_irq_follows: assert property (@(posedge clk) // RULE10
    disable iff (sys_rst)
    (|(irq_status_reg & irq_mask_reg & irq_en_reg)) |=> irq)
    else $error("interrupt not raised");

  // nothing pending keeps irq low
  a_irq_low: assert property (@(posedge clk) // RULE11
    disable iff (sys_rst)
    !(|(irq_status_reg & irq_mask_reg & irq_en_reg)) |=> !irq)
    else $error("interrupt raised with nothing pending");

  // read data is zero outside the cycle after a read
  a_rdata_idle: assert property (@(posedge clk)
    disable iff (sys_rst)
    !reg_rd |=> (reg_rdata == 32'h0))
    else $error("read data outside read cycle");

  // the set register reads back as zero
  a_rd_set_zero: assert property (@(posedge clk)
    disable iff (sys_rst)
    (reg_rd && (reg_addr == TIE_ADDR_EN_SET)) |=> (reg_rdata == 32'h0))
    else $error("set register read not zero");

  // ----------------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------------
  c_set: cover property (@(posedge clk) disable iff (sys_rst) wr_set);
  c_clr: cover property (@(posedge clk) disable iff (sys_rst)
    wr_clr ##1 (irq_en_reg == 32'h0));
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
  c_match: cover property (@(posedge clk) disable iff (sys_rst)
    evt_vec[0] && irq_en_reg[0]);
  c_rd_en: cover property (@(posedge clk) disable iff (sys_rst)
    reg_rd && (reg_addr == TIE_ADDR_EN_RD));

endmodule : tie_top

`default_nettype wire

/* File: bench/tie_top_tb.sv */
// Purpose: self-checking bench for the timer interrupt-enable block
// Assumes: register port with read data one cycle after the read strobe
// Notes: match events are made by stepping counters onto compare values, overflow events by pulsing tmr_ovf

`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// compare helper
// ----------------------------------------------------------------------
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); \
  end \
end

module tie_top_tb;
  import tie_pkg::*;

  localparam int W = 16;             // counter width under test
  localparam logic [W-1:0] CA = 16'h0010; // first compare value
  localparam logic [W-1:0] CB = 16'h0020; // second compare value

  logic clk = 1'b0;                  // 20 MHz bus clock
  logic sys_rst = 1'b1;              // async reset, high
  logic [7:0] reg_addr = 8'h00;      // register address
  logic [31:0] reg_wdata = 32'h0;    // write data
  logic reg_wr = 1'b0;               // write strobe
  logic reg_rd = 1'b0;               // read strobe
  logic [31:0] reg_rdata;            // read data
  logic [6*W-1:0] tmr_cnt = '0;      // timer counters
  logic [6*W-1:0] tmr_cmp_a = {6{CA}}; // first compares
  logic [6*W-1:0] tmr_cmp_b = {6{CB}}; // second compares
  logic [5:0] tmr_ovf = 6'h00;       // overflow pulses
  logic irq;                         // interrupt output
  int mismatches = 0;                // failed compares
  int n_tests = 0;                   // compares made
  logic [31:0] b;                    // one-hot source bit

  // ----------------------------------------------------------------------
  // clock and device
  // ----------------------------------------------------------------------
  always #25 clk = ~clk;

  tie_top #(.W(W)) u_tie_top (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tmr_cnt(tmr_cnt), .tmr_cmp_a(tmr_cmp_a),
    .tmr_cmp_b(tmr_cmp_b), .tmr_ovf(tmr_ovf), .irq(irq)
  );

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data checked in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
  endtask : rd

  // first match, second match, then overflow on one timer
  task automatic fire(input int t);
    @(posedge clk);
    tmr_cnt[t*W +: W] <= CA;
    @(posedge clk);
    tmr_cnt[t*W +: W] <= CB;
    @(posedge clk);
    tmr_cnt[t*W +: W] <= '0;
    tmr_ovf[t] <= 1'b1;
    @(posedge clk);
    tmr_ovf <= 6'h00;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : fire

  // verdict and end of run
  task automatic results;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // hang guard, far beyond the few hundred cycles the tests need
  // ----------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(TIE_ADDR_EN_RD, TIE_RST);
    `CHK(irq, 1'b0)
    $display("test reset done");
    // reserved bits ignored, zeros leave enables alone
    wr(TIE_ADDR_EN_SET, 32'hffff_ffff);
    rd(TIE_ADDR_EN_RD, TIE_VALID);
    wr(TIE_ADDR_EN_SET, 32'h0);
    wr(TIE_ADDR_EN_CLR, 32'h0);
    rd(TIE_ADDR_EN_RD, TIE_VALID);
    rd(TIE_ADDR_EN_SET, 32'h0);
    rd(8'h44, 32'h0);
    wr(TIE_ADDR_EN_CLR, 32'hffff_ffff);
    rd(TIE_ADDR_EN_RD, 32'h0);
    $display("test set clear words done");
    // each source alone: enabled it reaches status and irq, then not
    wr(TIE_ADDR_MASK, TIE_VALID);
    for (int t = 0; t < TIE_TIMERS; t++) begin
      for (int s = 0; s < 3; s++) begin
        b = 32'h1 << (t * TIE_NIB + s);
        wr(TIE_ADDR_EN_SET, b);
        rd(TIE_ADDR_EN_RD, b);
        fire(t);
        rd(TIE_ADDR_STATUS, b);
        `CHK(irq, 1'b1)
        wr(TIE_ADDR_EN_CLR, b);
        wr(TIE_ADDR_STATUS, b);
        rd(TIE_ADDR_EN_RD, 32'h0);
        fire(t);
        rd(TIE_ADDR_STATUS, 32'h0);
        `CHK(irq, 1'b0)
      end
    end
    $display("test per source done");
    // mask holds irq low, unmask raises it, status clear drops it
    wr(TIE_ADDR_MASK, 32'h0);
    wr(TIE_ADDR_EN_SET, 32'h4);
    fire(0);
    `CHK(irq, 1'b0)
    wr(TIE_ADDR_MASK, 32'h4);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr(TIE_ADDR_STATUS, 32'h4);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    $display("test mask done");
    results();
  end

endmodule : tie_top_tb

`default_nettype wire
